// file: src/crpc_cfg.svh
`ifndef CRPC_CFG_SVH
`define CRPC_CFG_SVH
// Register byte addresses on the APB bus.
`define CRPC_ADDR_CTRL1     12'h000
`define CRPC_ADDR_CTRL3     12'h004
`define CRPC_ADDR_RATE      12'h008
`define CRPC_ADDR_ADC_GAIN  12'h00C
`define CRPC_ADDR_DAC_GAIN  12'h010
`define CRPC_ADDR_MIC_TONE  12'h014
`define CRPC_ADDR_CTRL6     12'h018
`define CRPC_ADDR_STATUS    12'h01C
`define CRPC_ADDR_SAMPLE    12'h020
// Control register 1 fields.
`define CRPC_C1_FILT_IIR    5
`define CRPC_C1_ALOOP       2
`define CRPC_C1_DLOOP       1
// Control register 3 fields.
`define CRPC_C3_OSR_HI      4
`define CRPC_C3_OSR_LO      3
// Rate register fields: first divider code in [6:0], second in [11:8], third in [14:12].
`define CRPC_RATE_M_LSB     0
`define CRPC_RATE_N_LSB     8
`define CRPC_RATE_P_LSB     12
// Reset value: first and second dividers 1, third divider 8 (codes are value minus one).
`define CRPC_RATE_RESET     32'h0000_7000
// Mic/sidetone register fields.
`define CRPC_MT_TONE_LSB    3
`define CRPC_MT_PRE_LSB     0
// Control register 6 fields.
`define CRPC_C6_SPK_DIFF    7
`define CRPC_C6_SRC_LSB     1
// Gain code that selects mute.
`define CRPC_GAIN_MUTE      6'h3F
// Fixed frame-sync pre-divide and ADC oversampling.
`define CRPC_FS_PREDIV      16
`define CRPC_ADC_OSR        128
// Filter group delays in sample periods.
`define CRPC_FIR_DEC_DELAY  17
`define CRPC_FIR_INT_DELAY  18
`endif

// file: src/crpc_pkg.sv
package crpc_pkg;
    typedef enum logic [2:0] {
        CRPC_SRC_DIFF = 3'b001,
        CRPC_SRC_MIC_SB = 3'b010,
        CRPC_SRC_MIC_PD = 3'b100
    } crpc_src_e;
    typedef logic [15:0] crpc_word_t;
endpackage : crpc_pkg

// file: src/crpc_divider.sv
`timescale 1ns/1ns
`default_nettype none
`include "crpc_cfg.svh"
module crpc_divider
    import crpc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [6:0]  m_code,
    input  wire logic [3:0]  n_code,
    input  wire logic [2:0]  p_code,
    output logic             frame_sync,
    output logic             sample_tick,
    output logic             mod_tick
);
    logic [3:0]  pre_cnt;
    logic [6:0]  m_cnt;
    logic [3:0]  n_cnt;
    logic [2:0]  p_cnt;
    logic [6:0]  m_lat;
    logic [3:0]  n_lat;
    logic [2:0]  p_lat;
    logic [3:0]  next_pre_cnt;
    logic [6:0]  next_m_cnt;
    logic [3:0]  next_n_cnt;
    logic [2:0]  next_p_cnt;
    logic [6:0]  next_m_lat;
    logic [3:0]  next_n_lat;
    logic [2:0]  next_p_lat;
    logic        next_frame_sync;
    logic        next_sample_tick;
    logic        next_mod_tick;
    logic        wrap;
    logic [6:0]  mod_cnt;
    logic [6:0]  next_mod_cnt;
    logic        pre_wrap;

    // Cascade of 16 x M x N x P counters; divider values latch only at period end.
    always_comb begin
        pre_wrap     = (pre_cnt == 4'hF);
        wrap         = pre_wrap && (m_cnt == m_lat) && (n_cnt == n_lat) && (p_cnt == p_lat);
        next_pre_cnt = pre_cnt + 4'h1;
        next_m_cnt   = m_cnt;
        next_n_cnt   = n_cnt;
        next_p_cnt   = p_cnt;
        next_m_lat   = m_lat;
        next_n_lat   = n_lat;
        next_p_lat   = p_lat;
        if (pre_wrap) begin
            next_m_cnt = (m_cnt == m_lat) ? 7'h00 : m_cnt + 7'h01;
            if (m_cnt == m_lat) begin
                next_n_cnt = (n_cnt == n_lat) ? 4'h0 : n_cnt + 4'h1;
                if (n_cnt == n_lat) begin
                    next_p_cnt = (p_cnt == p_lat) ? 3'h0 : p_cnt + 3'h1;
                end
            end
        end
        if (wrap) begin
            next_m_lat = m_code;
            next_n_lat = n_code;
            next_p_lat = p_code;
        end
        // Low for exactly one clock at each period boundary, so it returns high even at N = P = 1.
        next_frame_sync  = !wrap;
        next_sample_tick = wrap;
        next_mod_cnt     = mod_cnt + 7'h01;
        next_mod_tick    = (mod_cnt == 7'h7F);
    end

    // Counter registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt     <= 4'h0;
            m_cnt       <= 7'h00;
            n_cnt       <= 4'h0;
            p_cnt       <= 3'h0;
            m_lat       <= 7'h00;
            n_lat       <= 4'h0;
            p_lat       <= 3'h7;
            frame_sync  <= 1'b1;
            sample_tick <= 1'b0;
            mod_cnt     <= 7'h00;
            mod_tick    <= 1'b0;
        end else begin
            pre_cnt     <= next_pre_cnt;
            m_cnt       <= next_m_cnt;
            n_cnt       <= next_n_cnt;
            p_cnt       <= next_p_cnt;
            m_lat       <= next_m_lat;
            n_lat       <= next_n_lat;
            p_lat       <= next_p_lat;
            frame_sync  <= next_frame_sync;
            sample_tick <= next_sample_tick;
            mod_cnt     <= next_mod_cnt;
            mod_tick    <= next_mod_tick;
        end
    end
endmodule : crpc_divider
`default_nettype wire

// file: src/crpc_delay_mem.sv
`timescale 1ns/1ns
`default_nettype none
module crpc_delay_mem
    import crpc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        wr_en,
    input  wire logic [4:0]  wr_addr,
    input  wire crpc_word_t  wr_data,
    input  wire logic [4:0]  rd_addr,
    output crpc_word_t       rd_data
);
    crpc_word_t mem [0:31];

    // Sample history store with registered read port.
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read data.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= 16'h0000;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : crpc_delay_mem
`default_nettype wire

// file: src/crpc_top.sv
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "crpc_cfg.svh"
module crpc_top
    import crpc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire crpc_word_t  adc_word,
    input  wire crpc_word_t  dac_in_word,
    input  wire logic        dac_power_req,
    output logic             frame_sync,
    output logic             mod_tick,
    output crpc_word_t       adc_out_word,
    output crpc_word_t       dac_mod_word,
    output logic [9:0]       dac_osr,
    output logic             analog_loop,
    output logic [5:0]       adc_gain,
    output logic [5:0]       dac_gain,
    output logic             dac_powered,
    output logic [2:0]       input_source,
    output logic [1:0]       mic_preamp_gain,
    output logic             speaker_diff,
    output logic             speaker_mute
);
    logic [31:0] ctrl1;
    logic [31:0] ctrl3;
    logic [31:0] rate;
    logic [5:0]  adc_gain_req;
    logic [5:0]  dac_gain_req;
    logic [31:0] mic_tone;
    logic [31:0] ctrl6;
    logic [31:0] next_ctrl1;
    logic [31:0] next_ctrl3;
    logic [31:0] next_rate;
    logic [5:0]  next_adc_gain_req;
    logic [5:0]  next_dac_gain_req;
    logic [31:0] next_mic_tone;
    logic [31:0] next_ctrl6;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        wr_acc;
    logic        rd_acc;
    logic        hit;
    logic        sample_tick;
    logic        fs_int;
    logic        mod_int;
    crpc_word_t  hist_rd;
    logic [4:0]  wr_ptr;
    logic [4:0]  next_wr_ptr;
    crpc_word_t  prev_adc;
    crpc_word_t  prev_dac;
    crpc_word_t  next_prev_adc;
    crpc_word_t  next_prev_dac;
    crpc_word_t  next_adc_out_word;
    crpc_word_t  next_dac_mod_word;
    logic [5:0]  next_adc_gain;
    logic [5:0]  next_dac_gain;
    logic        next_dac_powered;
    logic [9:0]  next_dac_osr;
    logic [2:0]  next_input_source;
    crpc_word_t  dac_src;
    crpc_word_t  tone;
    crpc_word_t  dec_word;
    logic        fir_mode;

    // Zero crossing: sign change between consecutive samples, or a zero sample.
    function automatic logic crpc_zero_cross(input crpc_word_t prev, input crpc_word_t cur);
        crpc_zero_cross = (prev[15] != cur[15]) || (cur == 16'h0000);
    endfunction : crpc_zero_cross

    // Shift a sample right arithmetically by the sidetone attenuation code plus one.
    // The count is four bits wide so that code 7 does not wrap round to no attenuation.
    function automatic crpc_word_t crpc_atten(input crpc_word_t w, input logic [2:0] sh);
        crpc_atten = crpc_word_t'($signed(w) >>> ({1'b0, sh} + 4'h1));
    endfunction : crpc_atten

    // Rate-setting counters and frame sync generation.
    crpc_divider u_div (
        .pclk        (pclk),
        .presetn     (presetn),
        .m_code      (rate[`CRPC_RATE_M_LSB +: 7]),
        .n_code      (rate[`CRPC_RATE_N_LSB +: 4]),
        .p_code      (rate[`CRPC_RATE_P_LSB +: 3]),
        .frame_sync  (fs_int),
        .sample_tick (sample_tick),
        .mod_tick    (mod_int)
    );

    // History of DAC samples to model the FIR group delay.
    crpc_delay_mem u_hist (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (sample_tick),
        .wr_addr (wr_ptr),
        .wr_data (dac_src),
        .rd_addr (5'(wr_ptr - 5'(`CRPC_FIR_INT_DELAY))),
        .rd_data (hist_rd)
    );

    // APB decode and register writes; a write commits at the edge that sees pready high.
    always_comb begin
        wr_acc            = psel && penable && pwrite && pready;
        rd_acc            = psel && penable && !pwrite && !pready;
        next_ctrl1        = ctrl1;
        next_ctrl3        = ctrl3;
        next_rate         = rate;
        next_adc_gain_req = adc_gain_req;
        next_dac_gain_req = dac_gain_req;
        next_mic_tone     = mic_tone;
        next_ctrl6        = ctrl6;
        next_prdata       = 32'h0000_0000;
        next_pready       = psel && penable && !pready;
        hit               = 1'b1;
        case (paddr)
            `CRPC_ADDR_CTRL1: begin
                if (wr_acc) next_ctrl1 = {24'h000000, pwdata[7:0] & 8'h26};
                next_prdata = ctrl1;
            end
            `CRPC_ADDR_CTRL3: begin
                if (wr_acc) next_ctrl3 = {24'h000000, pwdata[7:0] & 8'h18};
                next_prdata = ctrl3;
            end
            `CRPC_ADDR_RATE: begin
                if (wr_acc) next_rate = pwdata & 32'h0000_7F7F;
                next_prdata = rate;
            end
            `CRPC_ADDR_ADC_GAIN: begin
                if (wr_acc) next_adc_gain_req = pwdata[5:0];
                next_prdata = {26'h0000000, adc_gain_req};
            end
            `CRPC_ADDR_DAC_GAIN: begin
                if (wr_acc) next_dac_gain_req = pwdata[5:0];
                next_prdata = {26'h0000000, dac_gain_req};
            end
            `CRPC_ADDR_MIC_TONE: begin
                if (wr_acc) next_mic_tone = {24'h000000, pwdata[7:0] & 8'h3B};
                next_prdata = mic_tone;
            end
            `CRPC_ADDR_CTRL6: begin
                if (wr_acc) next_ctrl6 = {24'h000000, pwdata[7:0] & 8'hFE};
                next_prdata = ctrl6;
            end
            `CRPC_ADDR_STATUS: begin
                next_prdata = {18'h00000, dac_powered, dac_gain, adc_gain, frame_sync};
            end
            `CRPC_ADDR_SAMPLE: begin
                next_prdata = {adc_out_word, dac_mod_word};
            end
            default: begin
                hit         = 1'b0;
            end
        endcase
        if (!rd_acc) next_prdata = prdata;
        next_pslverr = next_pready && !hit;
    end

    // Register bank.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1        <= 32'h0000_0000;
            ctrl3        <= 32'h0000_0000;
            rate         <= `CRPC_RATE_RESET;
            adc_gain_req <= 6'h00;
            dac_gain_req <= 6'h00;
            mic_tone     <= 32'h0000_0000;
            ctrl6        <= 32'h0000_0000;
            prdata       <= 32'h0000_0000;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
        end else begin
            ctrl1        <= next_ctrl1;
            ctrl3        <= next_ctrl3;
            rate         <= next_rate;
            adc_gain_req <= next_adc_gain_req;
            dac_gain_req <= next_dac_gain_req;
            mic_tone     <= next_mic_tone;
            ctrl6        <= next_ctrl6;
            prdata       <= next_prdata;
            pready       <= next_pready;
            pslverr      <= next_pslverr;
        end
    end

    // Sample path: loopbacks, sidetone, filter delay, gains at zero crossings.
    always_comb begin
        fir_mode  = !ctrl1[`CRPC_C1_FILT_IIR];
        dec_word  = adc_word;
        tone      = crpc_atten(dec_word, mic_tone[`CRPC_MT_TONE_LSB +: 3]);
        // Analog loopback wins; digital loopback only acts without it.
        if (ctrl1[`CRPC_C1_DLOOP] && !ctrl1[`CRPC_C1_ALOOP]) begin
            dac_src = dec_word;
        end else begin
            dac_src = crpc_word_t'(dac_in_word + tone);
        end
        next_wr_ptr       = sample_tick ? 5'(wr_ptr + 5'h01) : wr_ptr;
        next_prev_adc     = sample_tick ? dec_word : prev_adc;
        next_prev_dac     = sample_tick ? dac_src : prev_dac;
        next_adc_out_word = sample_tick ? dec_word : adc_out_word;
        next_dac_mod_word = dac_mod_word;
        if (sample_tick) begin
            next_dac_mod_word = fir_mode ? hist_rd : dac_src;
        end
        next_adc_gain    = adc_gain;
        next_dac_gain    = dac_gain;
        next_dac_powered = dac_powered;
        if (sample_tick && crpc_zero_cross(prev_adc, dec_word)) begin
            next_adc_gain = adc_gain_req;
        end
        if (sample_tick && crpc_zero_cross(prev_dac, dac_src)) begin
            next_dac_gain    = dac_gain_req;
            next_dac_powered = dac_power_req;
        end
        case (ctrl3[`CRPC_C3_OSR_HI:`CRPC_C3_OSR_LO])
            2'b01:   next_dac_osr = 10'd256;
            2'b10:   next_dac_osr = 10'd512;
            default: next_dac_osr = 10'd128;
        endcase
        case (ctrl6[`CRPC_C6_SRC_LSB +: 2])
            2'b01:   next_input_source = CRPC_SRC_MIC_SB;
            2'b10:   next_input_source = CRPC_SRC_MIC_PD;
            default: next_input_source = CRPC_SRC_DIFF;
        endcase
    end

    // Path and output registers; every output is a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr          <= 5'h00;
            prev_adc        <= 16'h0000;
            prev_dac        <= 16'h0000;
            adc_out_word    <= 16'h0000;
            dac_mod_word    <= 16'h0000;
            adc_gain        <= 6'h00;
            dac_gain        <= 6'h00;
            dac_powered     <= 1'b0;
            dac_osr         <= 10'd128;
            input_source    <= CRPC_SRC_DIFF;
            analog_loop     <= 1'b0;
            mic_preamp_gain <= 2'b00;
            speaker_diff    <= 1'b0;
            speaker_mute    <= 1'b0;
            frame_sync      <= 1'b1;
            mod_tick        <= 1'b0;
        end else begin
            wr_ptr          <= next_wr_ptr;
            prev_adc        <= next_prev_adc;
            prev_dac        <= next_prev_dac;
            adc_out_word    <= next_adc_out_word;
            dac_mod_word    <= next_dac_mod_word;
            adc_gain        <= next_adc_gain;
            dac_gain        <= next_dac_gain;
            dac_powered     <= next_dac_powered;
            dac_osr         <= next_dac_osr;
            input_source    <= next_input_source;
            analog_loop     <= ctrl1[`CRPC_C1_ALOOP];
            mic_preamp_gain <= mic_tone[`CRPC_MT_PRE_LSB +: 2];
            speaker_diff    <= ctrl6[`CRPC_C6_SPK_DIFF];
            speaker_mute    <= (next_dac_gain == `CRPC_GAIN_MUTE);
            frame_sync      <= fs_int;
            mod_tick        <= mod_int;
        end
    end

    // Checks on the guarded behaviour.
    a_apb_ready_one: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("pready held more than one cycle");
    a_osr_decode: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl3[4:3] == 2'b00) |=> (dac_osr == 10'd128)) else $error("default osr wrong");
    a_dloop_path: assert property (@(posedge pclk) disable iff (!presetn)
        (sample_tick && ctrl1[1] && !ctrl1[2]) |=> (prev_dac == $past(adc_word)))
        else $error("digital loopback path wrong");
    a_aloop_prio: assert property (@(posedge pclk) disable iff (!presetn)
        (sample_tick && ctrl1[2]) |=> (prev_dac == $past(crpc_word_t'(dac_in_word + tone))))
        else $error("analog loopback lost priority");
    a_adc_gain_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !sample_tick |=> $stable(adc_gain)) else $error("adc gain moved between samples");
    a_dac_gain_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !sample_tick |=> $stable(dac_gain) && $stable(dac_powered))
        else $error("dac gain moved between samples");
    a_src_select: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl6[2:1] == 2'b01) |=> (input_source == CRPC_SRC_MIC_SB))
        else $error("input source decode wrong");
    a_mute_both: assert property (@(posedge pclk) disable iff (!presetn)
        (dac_gain == 6'h3F) |-> speaker_mute) else $error("speakers not muted together");
    a_mod_rate: assert property (@(posedge pclk) disable iff (!presetn)
        mod_tick |=> !mod_tick [*8]) else $error("modulator tick too frequent");

    // Checks on the configuration outputs and the per-sample path.
    a_fs_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        !frame_sync |=> frame_sync) else $error("frame sync low too long");
    a_osr_half: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl3[4:3] == 2'b01) |=> (dac_osr == 10'd256)) else $error("osr 256 decode wrong");
    a_preamp_follow: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (mic_preamp_gain == $past(mic_tone[1:0]))) else $error("preamp gain wrong");
    a_spk_follow: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (speaker_diff == $past(ctrl6[7]))) else $error("speaker mode wrong");
    a_aloop_follow: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (analog_loop == $past(ctrl1[2]))) else $error("analog loop flag wrong");
    a_fir_path: assert property (@(posedge pclk) disable iff (!presetn)
        (sample_tick && !ctrl1[5]) |=> (dac_mod_word == $past(hist_rd)))
        else $error("fir path not delayed");
    a_iir_path: assert property (@(posedge pclk) disable iff (!presetn)
        (sample_tick && ctrl1[5]) |=> (dac_mod_word == $past(dac_src)))
        else $error("iir path delayed");
    a_adc_gain_zc: assert property (@(posedge pclk) disable iff (!presetn)
        (sample_tick && (prev_adc[15] != adc_word[15])) |=> (adc_gain == $past(adc_gain_req)))
        else $error("adc gain not applied at crossing");
    a_dac_power_zc: assert property (@(posedge pclk) disable iff (!presetn)
        (sample_tick && (prev_dac[15] != dac_src[15])) |=> (dac_powered == $past(dac_power_req)))
        else $error("dac power not applied at crossing");
endmodule : crpc_top
`default_nettype wire

// file: verif/crpc_dsp_model.sv
`timescale 1ns/1ns
`default_nettype none
module crpc_dsp_model
    import crpc_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic frame_sync,
    input  wire logic hold_sign,
    output crpc_word_t adc_word,
    output crpc_word_t dac_in_word
);
    logic fs_q;
    logic flip;
    // New samples launch at each frame-sync fall; a held sign never crosses zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_q <= 1'b1;
            flip <= 1'b0;
            adc_word <= 16'h0064;
            dac_in_word <= 16'h0032;
        end else begin
            fs_q <= frame_sync;
            if (fs_q && !frame_sync) begin
                flip <= ~flip;
                adc_word <= (hold_sign || flip) ? 16'h0064 : 16'hFF9C;
                dac_in_word <= (hold_sign || flip) ? 16'h0032 : 16'hFFCE;
            end
        end
    end
endmodule : crpc_dsp_model
`default_nettype wire

// file: verif/crpc_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module crpc_top_tb_top;
    import crpc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, hold_sign;
    logic        dac_power_req, frame_sync, analog_loop, dac_powered, speaker_diff;
    logic        speaker_mute, mod_tick;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  dac_osr;
    logic [5:0]  adc_gain, dac_gain;
    logic [2:0]  input_source;
    logic [1:0]  mic_preamp_gain;
    crpc_word_t  adc_word, dac_in_word, adc_out_word, dac_mod_word;
    int          num_errors, comparisons, cycles, mod_ticks, m0;
    longint      t0;
    crpc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .adc_word(adc_word),
        .dac_in_word(dac_in_word), .dac_power_req(dac_power_req),
        .frame_sync(frame_sync), .mod_tick(mod_tick), .adc_out_word(adc_out_word),
        .dac_mod_word(dac_mod_word), .dac_osr(dac_osr), .analog_loop(analog_loop),
        .adc_gain(adc_gain), .dac_gain(dac_gain), .dac_powered(dac_powered),
        .input_source(input_source), .mic_preamp_gain(mic_preamp_gain),
        .speaker_diff(speaker_diff), .speaker_mute(speaker_mute));
    crpc_dsp_model dsp (.pclk(pclk), .presetn(presetn), .frame_sync(frame_sync),
        .hold_sign(hold_sign), .adc_word(adc_word), .dac_in_word(dac_in_word));
    // Clock of 100 ns period.
    always #50 pclk = ~pclk;
    // Cycle ceiling cuts a hung run short.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (mod_tick) mod_ticks <= mod_ticks + 1;
        if (cycles == 60000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One APB transfer; request held until pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        chk("pslverr", {31'h0, a > 12'h020}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic frames(input int n);
        repeat (n) @(negedge frame_sync);
    endtask : frames
    task automatic final_report();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, hold_sign, dac_power_req} = '0;
        paddr = '0;
        pwdata = '0;
        num_errors = 0;
        comparisons = 0;
        cycles = 0;
        mod_ticks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk("fs_idle", 32'h1, {31'h0, frame_sync});
        chk("osr_rst", 32'h80, {22'h0, dac_osr});
        chk("src_rst", 32'h1, {29'h0, input_source});
        apb(1'b0, 12'h008, 32'h0);
        chk("rate_rst", 32'h0000_7000, rd);
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped", 32'h0, rd);
        frames(1);
        t0 = $time;
        m0 = mod_ticks;
        frames(1);
        chk("period_rst", 32'd128, 32'(($time - t0) / 100));
        chk("mod_ticks", 32'd1, 32'(mod_ticks - m0));
        t0 = $time;
        apb(1'b1, 12'h008, 32'h0000_0001);
        frames(1);
        chk("period_old", 32'd128, 32'(($time - t0) / 100));
        t0 = $time;
        frames(1);
        chk("period_new", 32'd32, 32'(($time - t0) / 100));
        // Slow rate keeps the high oversampling ratios legal.
        apb(1'b1, 12'h008, 32'h0000_700F);
        for (int i = 1; i <= 3; i++) begin
            apb(1'b1, 12'h004, 32'(i % 3) << 3);
            frames(2);
            chk("dac_osr", 32'd128 << (i % 3), {22'h0, dac_osr});
        end
        apb(1'b1, 12'h008, 32'h0000_7000);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h018, {24'h0, i[0], 4'h0, i[1:0], 1'b0});
            apb(1'b1, 12'h014, {26'h0, 3'h5, 1'b0, i[1:0]});
            repeat (2) @(posedge pclk);
            chk("src", (i == 1) ? 2 : (i == 2) ? 4 : 1, {29'h0, input_source});
            chk("preamp", i, {30'h0, mic_preamp_gain});
            chk("spk_diff", i % 2, {31'h0, speaker_diff});
        end
        // Both loopbacks set: the analog one must win.
        apb(1'b1, 12'h000, 32'h0000_0026);
        repeat (2) @(posedge pclk);
        chk("aloop", 32'h1, {31'h0, analog_loop});
        hold_sign <= 1'b1;
        frames(2);
        apb(1'b1, 12'h00C, 32'h0000_0005);
        apb(1'b1, 12'h010, 32'h0000_003F);
        frames(3);
        chk("adc_gain_held", 32'h0, {26'h0, adc_gain});
        chk("dac_gain_held", 32'h0, {26'h0, dac_gain});
        hold_sign <= 1'b0;
        dac_power_req <= 1'b1;
        frames(4);
        chk("adc_gain", 32'h5, {26'h0, adc_gain});
        chk("dac_gain", 32'h3F, {26'h0, dac_gain});
        chk("dac_pwr", 32'h1, {31'h0, dac_powered});
        chk("spk_mute", 32'h1, {31'h0, speaker_mute});
        // Constant positive words: loopback in IIR mode, then an 18-sample FIR step.
        hold_sign <= 1'b1;
        apb(1'b1, 12'h000, 32'h0000_0022);
        frames(2);
        chk("dloop", 32'h64, {16'h0, dac_mod_word});
        chk("adc_out", 32'h64, {16'h0, adc_out_word});
        apb(1'b1, 12'h000, 32'h0000_0002);
        frames(18);
        apb(1'b1, 12'h000, 32'h0000_0000);
        frames(18);
        chk("fir_old", 32'h64, {16'h0, dac_mod_word});
        frames(1);
        chk("fir_new", 32'h33, {16'h0, dac_mod_word});
        final_report();
    end
endmodule : crpc_top_tb_top
`default_nettype wire
